// ==== rtl/motion_interrupt_pin_control.sv ====
// interrupt routing, pin drive and motion detection of a 3-axis accelerometer
// assumes events and samples are synchronous to mclk; registers via a simple port
`timescale 1ns/1ps
module motion_interrupt_pin_control #(
  parameter int TICK_CYCLES = motion_irq_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // data path events
  input wire logic newSample,
  input wire logic watermarkLevel,
  input wire logic fullLevel,
  // samples
  input wire logic sampleValid,
  input wire logic [11:0] accelX,
  input wire logic [11:0] accelY,
  input wire logic [11:0] accelZ,
  input wire logic [3:0] rangeCode,
  // interrupt pins
  output logic firstIrqPinOut,
  output logic firstIrqPinOe,
  output logic secondIrqPinOut,
  output logic secondIrqPinOe,
  // motion event pulses
  output logic slopeMotionPulse,
  output logic sigmotionPulse
);

  typedef struct packed {
    logic [7:0] axisEn;
    logic [7:0] map1;
    logic [7:0] map2;
    logic [7:0] pinCfg;
    logic [7:0] holdCfg;
    logic [7:0] slopeDur;
    logic [7:0] slopeThr;
    logic [7:0] skipLo;
    logic [7:0] sigCtrl;
    logic [7:0] proof;
    logic [7:0] rdData;
    logic clrPulse;
    logic [11:0] prevX;
    logic [11:0] prevY;
    logic [11:0] prevZ;
    logic havePrev;
    logic [2:0] slopeCnt;
    logic anyPulse;
    logic sigPulse;
    logic [15:0] tickCnt;
    logic tick;
    motion_irq_pkg::sig_state_t sig;
    logic [6:0] sigTicks;
    logic [8:0] sigSteps;
    logic [1:0] pinOut;
    logic [1:0] pinOe;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t n;
  logic firstActive;
  logic secondActive;
  logic firstSource;
  logic secondSource;
  logic motionNow;

  // magnitude of the change between two samples
  function automatic logic [12:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
    logic signed [12:0] d;
    d = 13'(signed'(a)) - 13'(signed'(b));
    abs_diff = d[12] ? 13'(-d) : 13'(d);
  endfunction : abs_diff

  // slope in mg against setting times the range step, both scaled to 1/100 mg
  function automatic logic over_thr(input logic [12:0] diff, input logic [7:0] thr,
                                    input logic [3:0] range);
    logic [15:0] step;
    logic [15:0] span;
    logic [47:0] lhs;
    logic [47:0] rhs;
    case (range)
      motion_irq_pkg::RANGE_4G: begin
        step = motion_irq_pkg::THR_STEP_4G;
        span = motion_irq_pkg::SPAN_4G_MG;
      end
      motion_irq_pkg::RANGE_8G: begin
        step = motion_irq_pkg::THR_STEP_8G;
        span = motion_irq_pkg::SPAN_8G_MG;
      end
      default: begin
        step = motion_irq_pkg::THR_STEP_2G;
        span = motion_irq_pkg::SPAN_2G_MG;
      end
    endcase
    lhs = 48'(diff) * 48'(span) * 48'(motion_irq_pkg::CENTI);
    rhs = 48'(thr) * 48'(step) * 48'(motion_irq_pkg::SAMPLE_COUNTS);
    over_thr = lhs > rhs;
  endfunction : over_thr

  // any enabled axis over threshold on this sample
  always_comb begin
    motionNow = sampleValid && s.havePrev && (
      (s.axisEn[0] && over_thr(abs_diff(accelX, s.prevX), s.slopeThr, rangeCode)) ||
      (s.axisEn[1] && over_thr(abs_diff(accelY, s.prevY), s.slopeThr, rangeCode)) ||
      (s.axisEn[2] && over_thr(abs_diff(accelZ, s.prevZ), s.slopeThr, rangeCode)));
  end

  // event routing onto each pin
  always_comb begin
    firstSource = (s.map2[motion_irq_pkg::NEW_TO_FIRST_BIT] && newSample) ||
                  (s.map2[motion_irq_pkg::WM_TO_FIRST_BIT] && watermarkLevel) ||
                  (s.map2[motion_irq_pkg::FULL_TO_FIRST_BIT] && fullLevel) ||
                  (s.map1[motion_irq_pkg::SIG_TO_FIRST_BIT] && s.sigPulse) ||
                  (s.map1[motion_irq_pkg::SLOPE_TO_FIRST_BIT] && s.anyPulse);
    secondSource = (s.map2[motion_irq_pkg::NEW_TO_SECOND_BIT] && newSample) ||
                   (s.map2[motion_irq_pkg::FULL_TO_SECOND_BIT] && fullLevel) ||
                   (s.map2[motion_irq_pkg::WM_TO_SECOND_BIT] && watermarkLevel) ||
                   (s.map1[motion_irq_pkg::SIG_TO_SECOND_BIT] && s.sigPulse) ||
                   (s.map1[motion_irq_pkg::SLOPE_TO_SECOND_BIT] && s.anyPulse);
  end

  always_comb begin
    n = s;
    n.clrPulse = 1'b0;
    n.anyPulse = 1'b0;
    n.sigPulse = 1'b0;

    // register writes
    if (regWrEn) begin
      case (regAddr)
        motion_irq_pkg::ADDR_AXIS_EN: n.axisEn = regWrData & motion_irq_pkg::MASK_AXIS_EN;
        motion_irq_pkg::ADDR_MAP1: n.map1 = regWrData & motion_irq_pkg::MASK_MAP1;
        motion_irq_pkg::ADDR_MAP2: n.map2 = regWrData & motion_irq_pkg::MASK_MAP2;
        motion_irq_pkg::ADDR_PINCFG: n.pinCfg = regWrData & motion_irq_pkg::MASK_PINCFG;
        motion_irq_pkg::ADDR_HOLD: begin
          n.holdCfg = regWrData & motion_irq_pkg::MASK_HOLD;
          n.clrPulse = regWrData[motion_irq_pkg::HOLD_CLEAR_BIT];
        end
        motion_irq_pkg::ADDR_SLOPE_DUR: n.slopeDur = regWrData & motion_irq_pkg::MASK_SLOPE_DUR;
        motion_irq_pkg::ADDR_SLOPE_THR: n.slopeThr = regWrData & motion_irq_pkg::MASK_FULL;
        motion_irq_pkg::ADDR_SKIP_LO: n.skipLo = regWrData & motion_irq_pkg::MASK_FULL;
        motion_irq_pkg::ADDR_SIG_CTRL: n.sigCtrl = regWrData & motion_irq_pkg::MASK_SIG_CTRL;
        motion_irq_pkg::ADDR_PROOF: n.proof = regWrData & motion_irq_pkg::MASK_PROOF;
        default: n.axisEn = s.axisEn;
      endcase
    end

    // register reads, answered on the next edge
    if (regRdEn) begin
      case (regAddr)
        motion_irq_pkg::ADDR_AXIS_EN: n.rdData = s.axisEn;
        motion_irq_pkg::ADDR_MAP1: n.rdData = s.map1;
        motion_irq_pkg::ADDR_MAP2: n.rdData = s.map2;
        motion_irq_pkg::ADDR_PINCFG: n.rdData = s.pinCfg;
        motion_irq_pkg::ADDR_HOLD: n.rdData = s.holdCfg;
        motion_irq_pkg::ADDR_SLOPE_DUR: n.rdData = s.slopeDur;
        motion_irq_pkg::ADDR_SLOPE_THR: n.rdData = s.slopeThr;
        motion_irq_pkg::ADDR_SKIP_LO: n.rdData = s.skipLo;
        motion_irq_pkg::ADDR_SIG_CTRL: n.rdData = s.sigCtrl;
        motion_irq_pkg::ADDR_PROOF: n.rdData = s.proof;
        default: n.rdData = 8'h00;
      endcase
    end

    // base tick
    n.tick = 1'b0;
    if (s.tickCnt >= 16'(TICK_CYCLES - 1)) begin
      n.tickCnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.tickCnt = s.tickCnt + 16'h0001;
    end

    // any-motion: consecutive samples over threshold
    if (sampleValid) begin
      n.prevX = accelX;
      n.prevY = accelY;
      n.prevZ = accelZ;
      n.havePrev = 1'b1;
      if (!s.sigCtrl[motion_irq_pkg::SLOPE_EN_BIT] || !motionNow) begin
        n.slopeCnt = 3'h0;
      end else if (s.slopeCnt <= 3'(s.slopeDur[1:0])) begin
        n.slopeCnt = s.slopeCnt + 3'h1;
        n.anyPulse = (s.slopeCnt == 3'(s.slopeDur[1:0]));
      end
    end

    // significant motion: skip, then proof
    case (s.sig)
      motion_irq_pkg::SIG_IDLE: begin
        if (motionNow) begin
          n.sig = motion_irq_pkg::SIG_SKIP;
          n.sigSteps = {s.sigCtrl[motion_irq_pkg::SKIP_MSB_BIT], s.skipLo};
          n.sigTicks = 7'h00;
        end
      end
      motion_irq_pkg::SIG_SKIP: begin
        if (s.sigSteps == 9'h000) begin
          n.sig = motion_irq_pkg::SIG_PROOF;
          n.sigSteps = {2'b00, s.proof[6:0]};
          n.sigTicks = 7'h00;
        end
      end
      motion_irq_pkg::SIG_PROOF: begin
        if (motionNow) begin
          n.sigPulse = 1'b1;
          n.sig = motion_irq_pkg::SIG_IDLE;
        end else if (s.sigSteps == 9'h000) begin
          n.sig = motion_irq_pkg::SIG_IDLE;
        end
      end
      default: n.sig = motion_irq_pkg::SIG_IDLE;
    endcase
    if (s.sig != motion_irq_pkg::SIG_IDLE && s.sigSteps != 9'h000 && s.tick) begin
      if (s.sigTicks == motion_irq_pkg::SIG_STEP_TICKS - 7'h01) begin
        n.sigTicks = 7'h00;
        n.sigSteps = s.sigSteps - 9'h001;
      end else begin
        n.sigTicks = s.sigTicks + 7'h01;
      end
    end
    if (!s.sigCtrl[motion_irq_pkg::SIG_EN_BIT]) begin
      n.sig = motion_irq_pkg::SIG_IDLE;
      n.sigPulse = 1'b0;
    end

    // polarity and drive type applied last
    if (s.pinCfg[motion_irq_pkg::FIRST_DRIVE_BIT]) begin
      n.pinOut[0] = 1'b0;
      n.pinOe[0] = !(firstActive == s.pinCfg[motion_irq_pkg::FIRST_POL_BIT]);
    end else begin
      n.pinOut[0] = firstActive == s.pinCfg[motion_irq_pkg::FIRST_POL_BIT];
      n.pinOe[0] = 1'b1;
    end
    if (s.pinCfg[motion_irq_pkg::SECOND_DRIVE_BIT]) begin
      n.pinOut[1] = 1'b0;
      n.pinOe[1] = !(secondActive == s.pinCfg[motion_irq_pkg::SECOND_POL_BIT]);
    end else begin
      n.pinOut[1] = secondActive == s.pinCfg[motion_irq_pkg::SECOND_POL_BIT];
      n.pinOe[1] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.pinCfg <= motion_irq_pkg::RST_PINCFG;
      s.slopeThr <= motion_irq_pkg::RST_SLOPE_THR;
      s.skipLo <= motion_irq_pkg::RST_SKIP_LO;
      s.sigCtrl <= motion_irq_pkg::RST_SIG_CTRL;
      s.proof <= motion_irq_pkg::RST_PROOF;
      s.axisEn <= motion_irq_pkg::RST_ZERO;
      s.pinOut <= 2'b00;
      s.pinOe <= 2'b11;
      s.sig <= motion_irq_pkg::SIG_IDLE;
    end else begin
      s <= n;
    end
  end

  // hold stage of each pin
  pin_hold_timer firstHold (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(s.tick),
    .source(firstSource),
    .mode(s.holdCfg[3:0]),
    .clear(s.clrPulse),
    .active(firstActive)
  );

  pin_hold_timer secondHold (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(s.tick),
    .source(secondSource),
    .mode(s.holdCfg[3:0]),
    .clear(s.clrPulse),
    .active(secondActive)
  );

  assign regRdData = s.rdData;
  assign firstIrqPinOut = s.pinOut[0];
  assign firstIrqPinOe = s.pinOe[0];
  assign secondIrqPinOut = s.pinOut[1];
  assign secondIrqPinOe = s.pinOe[1];
  assign slopeMotionPulse = s.anyPulse;
  assign sigmotionPulse = s.sigPulse;

endmodule : motion_interrupt_pin_control

// ==== rtl/motion_irq_pkg.sv ====
// register map, field layout, reset values and timing of the motion interrupt block
// assumes a 100 MHz mclk and 12-bit two's complement samples from the data path
package motion_irq_pkg;

  // register offsets
  localparam logic [7:0] ADDR_AXIS_EN = 8'h16;
  localparam logic [7:0] ADDR_MAP1 = 8'h19;
  localparam logic [7:0] ADDR_MAP2 = 8'h1a;
  localparam logic [7:0] ADDR_PINCFG = 8'h20;
  localparam logic [7:0] ADDR_HOLD = 8'h21;
  localparam logic [7:0] ADDR_SLOPE_DUR = 8'h27;
  localparam logic [7:0] ADDR_SLOPE_THR = 8'h28;
  localparam logic [7:0] ADDR_SKIP_LO = 8'h29;
  localparam logic [7:0] ADDR_SIG_CTRL = 8'h2a;
  localparam logic [7:0] ADDR_PROOF = 8'h2b;

  // writable bits of each register, the rest read as zero
  localparam logic [7:0] MASK_AXIS_EN = 8'h07;
  localparam logic [7:0] MASK_MAP1 = 8'ha5;
  localparam logic [7:0] MASK_MAP2 = 8'he7;
  localparam logic [7:0] MASK_PINCFG = 8'h0f;
  localparam logic [7:0] MASK_HOLD = 8'h0f;
  localparam logic [7:0] MASK_SLOPE_DUR = 8'h03;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_SIG_CTRL = 8'h07;
  localparam logic [7:0] MASK_PROOF = 8'h7f;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PINCFG = 8'h05;
  localparam logic [7:0] RST_SLOPE_THR = 8'h14;
  localparam logic [7:0] RST_SKIP_LO = 8'h96;
  localparam logic [7:0] RST_SIG_CTRL = 8'h02;
  localparam logic [7:0] RST_PROOF = 8'h32;

  // field positions
  localparam int SIG_TO_FIRST_BIT = 0;
  localparam int SLOPE_TO_FIRST_BIT = 2;
  localparam int SLOPE_TO_SECOND_BIT = 5;
  localparam int SIG_TO_SECOND_BIT = 7;
  localparam int NEW_TO_FIRST_BIT = 0;
  localparam int WM_TO_FIRST_BIT = 1;
  localparam int FULL_TO_FIRST_BIT = 2;
  localparam int FULL_TO_SECOND_BIT = 5;
  localparam int WM_TO_SECOND_BIT = 6;
  localparam int NEW_TO_SECOND_BIT = 7;
  localparam int FIRST_POL_BIT = 0;
  localparam int FIRST_DRIVE_BIT = 1;
  localparam int SECOND_POL_BIT = 2;
  localparam int SECOND_DRIVE_BIT = 3;
  localparam int HOLD_CLEAR_BIT = 7;
  localparam int SKIP_MSB_BIT = 0;
  localparam int SIG_EN_BIT = 1;
  localparam int SLOPE_EN_BIT = 2;

  // hold mode codes
  localparam logic [3:0] MODE_PLAIN_A = 4'h0;
  localparam logic [3:0] MODE_LATCH_A = 4'h7;
  localparam logic [3:0] MODE_PLAIN_B = 4'h8;
  localparam logic [3:0] MODE_LATCH_B = 4'hf;

  // range codes, threshold step in 1/100 mg and full span in mg
  localparam logic [3:0] RANGE_2G = 4'h3;
  localparam logic [3:0] RANGE_4G = 4'h5;
  localparam logic [3:0] RANGE_8G = 4'h8;
  localparam logic [15:0] THR_STEP_2G = 16'd391;
  localparam logic [15:0] THR_STEP_4G = 16'd781;
  localparam logic [15:0] THR_STEP_8G = 16'd1563;
  localparam logic [15:0] SPAN_2G_MG = 16'd4000;
  localparam logic [15:0] SPAN_4G_MG = 16'd8000;
  localparam logic [15:0] SPAN_8G_MG = 16'd16000;
  localparam logic [15:0] SAMPLE_COUNTS = 16'd4096;
  localparam logic [15:0] CENTI = 16'd100;

  // timing: a 250 us base tick drives every timer
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US = 250;
  localparam int TICK_CYCLES = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIG_STEP_MS = 20;
  localparam logic [6:0] SIG_STEP_TICKS = 7'(SIG_STEP_MS * 1000 / TICK_US);
  localparam int HOLD_250US_US = 250;
  localparam int HOLD_500US_US = 500;
  localparam int HOLD_1MS_US = 1000;
  localparam int HOLD_12P5MS_US = 12500;
  localparam int HOLD_25MS_US = 25000;
  localparam int HOLD_50MS_US = 50000;
  localparam int HOLD_250MS_MS = 250;
  localparam int HOLD_500MS_MS = 500;
  localparam int HOLD_1S_MS = 1000;
  localparam int HOLD_2S_MS = 2000;
  localparam int HOLD_4S_MS = 4000;
  localparam int HOLD_8S_MS = 8000;

  typedef enum logic [1:0] {
    SIG_IDLE = 2'b00,
    SIG_SKIP = 2'b01,
    SIG_PROOF = 2'b10
  } sig_state_t;

  // base ticks that a temporary hold mode keeps the pin asserted
  function automatic logic [15:0] hold_ticks(input logic [3:0] mode);
    case (mode)
      4'h1: hold_ticks = 16'(HOLD_250MS_MS * 1000 / TICK_US);
      4'h2: hold_ticks = 16'(HOLD_500MS_MS * 1000 / TICK_US);
      4'h3: hold_ticks = 16'(HOLD_1S_MS * 1000 / TICK_US);
      4'h4: hold_ticks = 16'(HOLD_2S_MS * 1000 / TICK_US);
      4'h5: hold_ticks = 16'(HOLD_4S_MS * 1000 / TICK_US);
      4'h6: hold_ticks = 16'(HOLD_8S_MS * 1000 / TICK_US);
      4'h9: hold_ticks = 16'(HOLD_250US_US / TICK_US);
      4'ha: hold_ticks = 16'(HOLD_500US_US / TICK_US);
      4'hb: hold_ticks = 16'(HOLD_1MS_US / TICK_US);
      4'hc: hold_ticks = 16'(HOLD_12P5MS_US / TICK_US);
      4'hd: hold_ticks = 16'(HOLD_25MS_US / TICK_US);
      4'he: hold_ticks = 16'(HOLD_50MS_US / TICK_US);
      default: hold_ticks = 16'h0000;
    endcase
  endfunction : hold_ticks

endpackage : motion_irq_pkg

// ==== rtl/pin_hold_timer.sv ====
// one interrupt pin's hold stage: non-latched, temporary or latched
// assumes tick is a one-cycle pulse every base tick period
`timescale 1ns/1ps
module pin_hold_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic source,
  input wire logic [3:0] mode,
  input wire logic clear,
  // result
  output logic active
);

  typedef struct packed {
    logic active;
    logic [15:0] ticks;
  } hold_state_t;

  hold_state_t s;
  hold_state_t n;

  always_comb begin
    n = s;
    if (mode == motion_irq_pkg::MODE_PLAIN_A || mode == motion_irq_pkg::MODE_PLAIN_B) begin
      n.active = source;
      n.ticks = 16'h0000;
    end else if (mode == motion_irq_pkg::MODE_LATCH_A || mode == motion_irq_pkg::MODE_LATCH_B) begin
      n.ticks = 16'h0000;
      if (source) begin
        n.active = 1'b1;
      end else if (clear) begin
        n.active = 1'b0;
      end
    end else begin
      if (source) begin
        n.ticks = motion_irq_pkg::hold_ticks(mode);
      end else if (tick && s.ticks != 16'h0000) begin
        n.ticks = s.ticks - 16'h0001;
      end
      n.active = source || (n.ticks != 16'h0000);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign active = s.active;

endmodule : pin_hold_timer

// ==== sim/motion_irq_assertions.sv ====
// port checker for the motion interrupt block
// assumes it is bound to every instance of the top module
`timescale 1ns/1ps
module motion_irq_assertions #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  // samples
  input wire logic sampleValid,
  // interrupt pins
  input wire logic firstIrqPinOut,
  input wire logic firstIrqPinOe,
  input wire logic secondIrqPinOut,
  input wire logic secondIrqPinOe,
  // motion pulses
  input wire logic slopeMotionPulse,
  input wire logic sigmotionPulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_map_reserved_zero: assert property (
    regRdEn && regAddr == motion_irq_pkg::ADDR_MAP2 |=> regRdData[4:3] == 2'b00)
    else $error("reserved routing bits read nonzero");
  a_cfg_reserved_zero: assert property (
    regRdEn && regAddr == motion_irq_pkg::ADDR_PINCFG |=> regRdData[7:4] == 4'h0)
    else $error("reserved pin config bits read nonzero");
  a_clear_reads_zero: assert property (
    regRdEn && regAddr == motion_irq_pkg::ADDR_HOLD |=> !regRdData[7])
    else $error("clear bit reads back set");
  a_dur_width_two: assert property (
    regRdEn && regAddr == motion_irq_pkg::ADDR_SLOPE_DUR |=> regRdData[7:2] == 6'h00)
    else $error("sample count field wider than two bits");
  a_ctrl_width_three: assert property (
    regRdEn && regAddr == motion_irq_pkg::ADDR_SIG_CTRL |=> regRdData[7:3] == 5'h00)
    else $error("motion control reserved bits set");
  a_first_drive_high: assert property (firstIrqPinOut |-> firstIrqPinOe)
    else $error("first pin high level while released");
  a_second_drive_high: assert property (secondIrqPinOut |-> secondIrqPinOe)
    else $error("second pin high level while released");
  a_slope_after_sample: assert property (slopeMotionPulse |-> $past(sampleValid))
    else $error("slope pulse without a sample");
  a_slope_one_cycle: assert property (slopeMotionPulse |=> !slopeMotionPulse)
    else $error("slope pulse longer than a cycle");
  a_sig_after_sample: assert property (sigmotionPulse |-> $past(sampleValid))
    else $error("sigmotion pulse without a sample");
  a_sig_one_cycle: assert property (sigmotionPulse |=> !sigmotionPulse)
    else $error("sigmotion pulse longer than a cycle");
  a_read_data_stands: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");
endmodule : motion_irq_assertions

bind motion_interrupt_pin_control motion_irq_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .regRdEn(regRdEn), .regAddr(regAddr),
  .regRdData(regRdData), .sampleValid(sampleValid), .firstIrqPinOut(firstIrqPinOut),
  .firstIrqPinOe(firstIrqPinOe), .secondIrqPinOut(secondIrqPinOut),
  .secondIrqPinOe(secondIrqPinOe), .slopeMotionPulse(slopeMotionPulse),
  .sigmotionPulse(sigmotionPulse));

// ==== sim/irq_host_model.sv ====
// host side of the two interrupt pins: resolves each wire level
// assumes a pull-up on both lines, as open-drain needs
`timescale 1ns/1ps
module irq_host_model (
  // first pin
  input wire logic firstOut,
  input wire logic firstOe,
  // second pin
  input wire logic secondOut,
  input wire logic secondOe,
  // wire levels
  output logic firstLevel,
  output logic secondLevel
);
  // a released pin floats up
  assign firstLevel = firstOe ? firstOut : 1'b1;
  assign secondLevel = secondOe ? secondOut : 1'b1;
endmodule : irq_host_model

// ==== sim/test_motion_interrupt_pin_control.sv ====
// self-checking bench for the motion interrupt block
// assumes the checker is bound and the host model resolves the pins
`timescale 1ns/1ps
module test_motion_interrupt_pin_control;
  localparam int TK = 4;
  logic mclk, rst_n, regWrEn, regRdEn, newSample, watermarkLevel, fullLevel, sampleValid;
  logic [7:0] regAddr, regWrData, regRdData, v, m;
  logic [11:0] accelX, accelY, accelZ;
  logic [3:0] rangeCode, c;
  logic [1:0] e;
  logic firstIrqPinOut, firstIrqPinOe, secondIrqPinOut, secondIrqPinOe;
  logic slopeMotionPulse, sigmotionPulse, firstLevel, secondLevel;
  int fails, cmp_count, cyc, pulses, sigs, t;
  logic [7:0] ra [11] = '{8'h16, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h27, 8'h28, 8'h29,
    8'h2a, 8'h2b, 8'h30};
  logic [7:0] rv [11] = '{0, 0, 0, 8'h05, 0, 0, 8'h14, 8'h96, 8'h02, 8'h32, 0};
  logic [7:0] rm [11] = '{8'h07, 8'ha5, 8'he7, 8'h0f, 8'h0f, 8'h03, 8'hff, 8'hff,
    8'h07, 8'h7f, 0};
  logic [3:0] tm [5] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'h1};
  logic [3:0] rg [3] = '{4'h3, 4'h5, 4'h8};
  logic [11:0] lo [3] = '{12'd4, 12'd3, 12'd4};

  motion_interrupt_pin_control #(.TICK_CYCLES(TK)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .newSample(newSample), .watermarkLevel(watermarkLevel),
    .fullLevel(fullLevel), .sampleValid(sampleValid), .accelX(accelX), .accelY(accelY),
    .accelZ(accelZ), .rangeCode(rangeCode), .firstIrqPinOut(firstIrqPinOut),
    .firstIrqPinOe(firstIrqPinOe), .secondIrqPinOut(secondIrqPinOut),
    .secondIrqPinOe(secondIrqPinOe), .slopeMotionPulse(slopeMotionPulse),
    .sigmotionPulse(sigmotionPulse));
  irq_host_model u_host (.firstOut(firstIrqPinOut), .firstOe(firstIrqPinOe),
    .secondOut(secondIrqPinOut), .secondOe(secondIrqPinOe), .firstLevel(firstLevel),
    .secondLevel(secondLevel));

  task automatic tally_and_finish();
    $display("TB: %0d fails, %0d compares", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    cycles(1);
    chk(regRdData, exp);
  endtask : rdc
  task automatic pinchk(input logic a1, input logic a2, input logic [3:0] k);
    logic e1, e2;
    e1 = a1 ? k[0] : ~k[0];
    e2 = a2 ? k[2] : ~k[2];
    chk({7'h0, firstLevel}, {7'h0, e1});
    chk({7'h0, firstIrqPinOe}, {7'h0, ~k[1] | ~e1});
    chk({7'h0, secondLevel}, {7'h0, e2});
    chk({7'h0, secondIrqPinOe}, {7'h0, ~k[3] | ~e2});
  endtask : pinchk
  task automatic samp(input logic [11:0] x);
    @(posedge mclk);
    sampleValid <= 1'b1;
    accelX <= x;
    accelY <= 12'($urandom);
    accelZ <= 12'($urandom);
    @(posedge mclk);
    sampleValid <= 1'b0;
    cycles(3);
  endtask : samp
  function automatic logic [1:0] route(input logic [7:0] r, input logic [2:0] ev);
    route[0] = (r[0] & ev[2]) | (r[1] & ev[1]) | (r[2] & ev[0]);
    route[1] = (r[7] & ev[2]) | (r[6] & ev[1]) | (r[5] & ev[0]);
  endfunction : route
  function automatic int ticks(input logic [3:0] k);
    case (k)
      4'h9: ticks = 1;
      4'ha: ticks = 2;
      4'hb: ticks = 4;
      4'hc: ticks = 50;
      default: ticks = 1000;
    endcase
  endfunction : ticks

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (slopeMotionPulse !== 1'b0) pulses++;
    if (sigmotionPulse !== 1'b0) sigs++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, regWrEn, regRdEn, newSample, watermarkLevel, fullLevel, sampleValid} = 7'h00;
    {regAddr, regWrData, accelX, accelY, accelZ} = 52'h0;
    rangeCode = 4'h3;
    void'($urandom(32'hdea98be7));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    cycles(2);
    pinchk(1'b0, 1'b0, 4'h5);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    for (int k = 0; k < 2; k++) begin
      foreach (ra[i]) begin
        v = k ? 8'($urandom) : 8'hff;
        wr(ra[i], v);
        rdc(ra[i], v & rm[i]);
      end
    end
    $display("registers done");
    wr(8'h2a, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h21, 8'h80);
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      m = 8'($urandom);
      wr(8'h20, {4'h0, c});
      wr(8'h21, {4'h0, i[4], 3'b000});
      wr(8'h1a, m);
      @(posedge mclk);
      {newSample, watermarkLevel, fullLevel} <= 3'($urandom);
      cycles(3);
      e = route(m, {newSample, watermarkLevel, fullLevel});
      pinchk(e[0], e[1], c);
    end
    {newSample, watermarkLevel, fullLevel} <= 3'b000;
    wr(8'h20, 8'h05);
    wr(8'h1a, 8'h81);
    $display("routing done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h21, {4'h0, tm[i]});
      @(posedge mclk);
      newSample <= 1'b1;
      @(posedge mclk);
      newSample <= 1'b0;
      t = ticks(tm[i]);
      cycles(1 + (t - 1) * TK);
      pinchk(1'b1, 1'b1, 4'h5);
      cycles(2 * TK + 4);
      pinchk(1'b0, 1'b0, 4'h5);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h21, i ? 8'h0f : 8'h07);
      @(posedge mclk);
      newSample <= 1'b1;
      @(posedge mclk);
      newSample <= 1'b0;
      cycles(20);
      pinchk(1'b1, 1'b1, 4'h5);
      wr(8'h21, i ? 8'h8f : 8'h87);
      cycles(4);
      pinchk(1'b0, 1'b0, 4'h5);
    end
    $display("hold modes done");
    wr(8'h1a, 8'h00);
    wr(8'h19, 8'h04);
    wr(8'h16, 8'h01);
    wr(8'h28, 8'h01);
    wr(8'h2a, 8'h04);
    for (int d = 0; d < 4; d++) begin
      wr(8'h27, 8'(d));
      samp(12'd0);
      samp(12'd0);
      wr(8'h19, d[0] ? 8'h20 : 8'h04);
      wr(8'h21, 8'h87);
      pulses = 0;
      for (int s = 0; s < d; s++) samp(s[0] ? 12'd0 : 12'd100);
      chk(8'(pulses), 8'h00);
      samp(d[0] ? 12'd0 : 12'd100);
      chk(8'(pulses), 8'h01);
      pinchk(~d[0], d[0], 4'h5);
    end
    wr(8'h27, 8'h00);
    foreach (rg[i]) begin
      rangeCode <= rg[i];
      samp(12'd0);
      samp(12'd0);
      pulses = 0;
      samp(lo[i]);
      chk(8'(pulses), 8'h00);
      samp(12'd0);
      samp(lo[i] + 12'd1);
      chk(8'(pulses), 8'h01);
    end
    wr(8'h2a, 8'h00);
    pulses = 0;
    samp(12'd100);
    samp(12'd0);
    chk(8'(pulses), 8'h00);
    $display("slope done");
    wr(8'h19, 8'h80);
    wr(8'h21, 8'h87);
    wr(8'h29, 8'h01);
    wr(8'h2b, 8'h01);
    wr(8'h2a, 8'h02);
    sigs = 0;
    samp(12'd100);
    cycles(100);
    samp(12'd0);
    chk(8'(sigs), 8'h00);
    pinchk(1'b0, 1'b0, 4'h5);
    cycles(300);
    samp(12'd100);
    chk(8'(sigs), 8'h01);
    pinchk(1'b0, 1'b1, 4'h5);
    $display("sigmotion done");
    tally_and_finish();
  end
endmodule : test_motion_interrupt_pin_control
